// ===== hw/spw_device.sv
// device end: password gate in front of protected commands
`include "spw_regs.svh"
`default_nettype none
module spw_device (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    spw_link_if.device link,
    input wire logic serial_mode_i,
    input wire logic on_chip_debug_i,
    input wire logic start_i,
    input wire spw_pkg::spw_byte_t cmd_i,
    output logic fl_rd_o,
    output spw_pkg::spw_addr_t fl_addr_o,
    input wire spw_pkg::spw_byte_t fl_data_i,
    output logic granted_o,
    output logic pw_error_o,
    output logic blank_o,
    output logic busy_o
);
    import spw_pkg::*;

    typedef struct packed {
        spw_dev_state_t st;
        logic [1:0] cnt;
        spw_addr_t pw_count_location;
        spw_addr_t pw_compare_start;
        spw_byte_t n;
        spw_byte_t idx;
        spw_byte_t prev;
        logic [1:0] run;
        logic blank;
        logic [5:0] bidx;
        logic rd;
        spw_addr_t addr;
        logic granted;
        logic err;
        logic tx_v;
        spw_byte_t tx_d;
        spw_byte_t cmd;
        logic busy;
        logic [1:0] mode_sync;
        logic [1:0] dbg_sync;
    } spw_dev_t;

    spw_dev_t r, next_r;

    function automatic logic in_user(input spw_addr_t a);
        in_user = (a >= `SPW_USER_LO) && (a <= `SPW_USER_HI);
    endfunction

    function automatic logic needs_pw(input spw_byte_t c);
        needs_pw = (c == `SPW_CMD_ERASE) || (c == `SPW_CMD_WRITE) || (c == `SPW_CMD_READ) ||
                   (c == `SPW_CMD_LOADER) || (c == `SPW_CMD_SECURE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.rd = 1'b0;
        next_r.tx_v = 1'b0;
        // mode pins pass two flip-flops before the gate reads them
        next_r.mode_sync = {r.mode_sync[0], serial_mode_i};
        next_r.dbg_sync = {r.dbg_sync[0], on_chip_debug_i};
        unique case (r.st)
            SPW_IDLE: begin
                if (start_i && (r.mode_sync[1] || r.dbg_sync[1])) begin
                    next_r.cmd = cmd_i;
                    next_r.granted = 1'b0;
                    next_r.busy = 1'b1;
                    next_r.bidx = 6'h00;
                    next_r.blank = 1'b1;
                    next_r.st = SPW_BLANK;
                end
            end
            SPW_BLANK: begin
                // scan top area one byte per two cycles
                if (!r.rd) begin
                    next_r.addr = `SPW_BLANK_LO + 17'(r.bidx);
                    next_r.rd = 1'b1;
                end else begin
                    if (fl_data_i != `SPW_ERASED) begin
                        next_r.blank = 1'b0;
                    end
                    next_r.bidx = r.bidx + 6'h01;
                    if (r.bidx == `SPW_BLANK_BYTES - 6'h01) begin
                        if (!needs_pw(r.cmd)) begin
                            next_r.granted = 1'b1;
                            next_r.busy = 1'b0;
                            next_r.st = SPW_IDLE;
                        end else begin
                            next_r.cnt = 2'd0;
                            next_r.st = SPW_ADDR_A;
                        end
                    end
                end
            end
            SPW_ADDR_A: begin
                if (link.rx_valid) begin
                    next_r.pw_count_location = {r.pw_count_location[8:0], link.rx_data};
                    next_r.cnt = r.cnt + 2'd1;
                    if (r.cnt == 2'd2) begin
                        next_r.cnt = 2'd0;
                        next_r.addr = {r.pw_count_location[8:0], link.rx_data};
                        if (!in_user({r.pw_count_location[8:0], link.rx_data})) begin
                            next_r.st = SPW_DEAD;
                        end else begin
                            next_r.rd = 1'b1;
                            next_r.st = SPW_RD_LEN;
                        end
                    end
                end
            end
            SPW_RD_LEN: begin
                next_r.n = fl_data_i;
                // first start address byte arrives while the length is read
                if (link.rx_valid) begin
                    next_r.pw_compare_start = {r.pw_compare_start[8:0], link.rx_data};
                    next_r.cnt = r.cnt + 2'd1;
                end
                if (!r.blank && fl_data_i <= `SPW_MIN_LEN) begin
                    next_r.st = SPW_DEAD;
                end else begin
                    next_r.st = SPW_ADDR_B;
                end
            end
            SPW_ADDR_B: begin
                if (link.rx_valid) begin
                    next_r.pw_compare_start = {r.pw_compare_start[8:0], link.rx_data};
                    next_r.cnt = r.cnt + 2'd1;
                    if (r.cnt == 2'd2) begin
                        next_r.idx = 8'h00;
                        next_r.run = 2'd0;
                        next_r.st = SPW_STRING;
                        if (r.blank) begin
                            if (!in_user({r.pw_compare_start[8:0], link.rx_data})) begin
                                next_r.st = SPW_DEAD;
                            end else if (r.cmd == `SPW_CMD_WRITE || r.cmd == `SPW_CMD_LOADER) begin
                                next_r.st = SPW_WAIT_MARK;
                            end else begin
                                next_r.st = SPW_GRANT;
                            end
                        end else if ({r.pw_compare_start[8:0], link.rx_data} < `SPW_USER_LO ||
                                     {r.pw_compare_start[8:0], link.rx_data} > `SPW_CMP_END - 17'(r.n)) begin
                            next_r.st = SPW_DEAD;
                        end
                    end
                end
            end
            SPW_STRING: begin
                if (link.rx_valid) begin
                    next_r.prev = link.rx_data;
                    next_r.run = (r.idx != 8'h00 && link.rx_data == r.prev) ? r.run + 2'd1 : 2'd0;
                    next_r.addr = r.pw_compare_start + 17'(r.idx);
                    next_r.rd = 1'b1;
                    next_r.st = SPW_CMP;
                end
            end
            SPW_CMP: begin
                if (fl_data_i != r.prev || r.run >= 2'd2) begin
                    next_r.st = SPW_DEAD;
                end else if (r.idx == r.n - 8'h01) begin
                    next_r.st = SPW_GRANT;
                end else begin
                    next_r.idx = r.idx + 8'h01;
                    next_r.st = SPW_STRING;
                end
            end
            SPW_WAIT_MARK: begin
                if (link.rx_valid && link.rx_data == `SPW_REC_MARK) begin
                    next_r.st = SPW_GRANT;
                end
            end
            SPW_GRANT: begin
                next_r.granted = 1'b1;
                next_r.busy = 1'b0;
                next_r.tx_v = 1'b1;
                next_r.tx_d = r.blank ? `SPW_STATUS_BLANK : `SPW_STATUS_OK;
                next_r.st = SPW_IDLE;
            end
            SPW_DEAD: begin
                next_r.err = 1'b1;
                next_r.busy = 1'b0;
                next_r.granted = 1'b0;
            end
            default: next_r.st = SPW_DEAD;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign link.tx_valid = r.tx_v;
    assign link.tx_data = r.tx_d;
    assign fl_rd_o = r.rd;
    assign fl_addr_o = r.addr;
    assign granted_o = r.granted;
    assign pw_error_o = r.err;
    assign blank_o = r.blank;
    assign busy_o = r.busy;
endmodule
`default_nettype wire

// ===== hw/spw_regs.svh
// constants of the serial programming password gate
`ifndef SPW_REGS_SVH
`define SPW_REGS_SVH
`define SPW_USER_LO 17'h0_1000
`define SPW_USER_HI 17'h1_FEFF
`define SPW_CMP_END 17'h1_FF00
`define SPW_BLANK_LO 17'h1_FFE0
`define SPW_BLANK_BYTES 6'h20
`define SPW_MIN_LEN 8'h07
`define SPW_ERASED 8'hFF
`define SPW_REC_MARK 8'h3A
`define SPW_CMD_ERASE 8'hF0
`define SPW_CMD_WRITE 8'h30
`define SPW_CMD_READ 8'h40
`define SPW_CMD_LOADER 8'h60
`define SPW_CMD_SECURE 8'hFA
`define SPW_STATUS_OK 8'h00
`define SPW_STATUS_BLANK 8'h01
`endif

// ===== hw/spw_pkg.sv
// types of the serial programming password gate
`default_nettype none
package spw_pkg;
    typedef logic [16:0] spw_addr_t;
    typedef logic [7:0] spw_byte_t;
    typedef enum logic [3:0] {
        SPW_IDLE = 4'h0,
        SPW_ADDR_A = 4'h1,
        SPW_RD_LEN = 4'h2,
        SPW_ADDR_B = 4'h3,
        SPW_BLANK = 4'h4,
        SPW_STRING = 4'h5,
        SPW_CMP = 4'h6,
        SPW_WAIT_MARK = 4'h7,
        SPW_GRANT = 4'h8,
        SPW_DEAD = 4'h9
    } spw_dev_state_t;
    typedef enum logic [1:0] {
        SPW_H_IDLE = 2'h0,
        SPW_H_SEND = 2'h1,
        SPW_H_WAIT = 2'h2
    } spw_host_state_t;
endpackage
`default_nettype wire

// ===== hw/spw_link_if.sv
// byte stream link between programming controller and device
`default_nettype none
interface spw_link_if;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_valid;
    logic [7:0] tx_data;
    modport device (input rx_valid, input rx_data, output tx_valid, output tx_data);
    modport host (output rx_valid, output rx_data, input tx_valid, input tx_data);
endinterface
`default_nettype wire

// ===== hw/spw_host.sv
// controller end: sends both addresses and the password string
`include "spw_regs.svh"
`default_nettype none
module spw_host (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    spw_link_if.host link,
    input wire logic go_i,
    input wire logic send_string_i,
    input wire spw_pkg::spw_addr_t count_addr_i,
    input wire spw_pkg::spw_addr_t start_addr_i,
    input wire spw_pkg::spw_byte_t str_len_i,
    output logic str_rd_o,
    output spw_pkg::spw_byte_t str_idx_o,
    input wire spw_pkg::spw_byte_t str_data_i,
    output logic done_o,
    output spw_pkg::spw_byte_t status_o
);
    import spw_pkg::*;

    typedef struct packed {
        spw_host_state_t st;
        logic [2:0] pos;
        spw_byte_t idx;
        logic send_str;
        logic ph;
        logic v;
        spw_byte_t d;
        logic done;
        spw_byte_t status;
    } spw_host_r_t;

    spw_host_r_t r, next_r;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.v = 1'b0;
        next_r.done = 1'b0;
        unique case (r.st)
            SPW_H_IDLE: begin
                if (go_i) begin
                    next_r.pos = 3'd0;
                    next_r.idx = 8'h00;
                    next_r.send_str = send_string_i;
                    next_r.st = SPW_H_SEND;
                end
            end
            SPW_H_SEND: begin
                unique case (r.pos)
                    3'd0: next_r.d = {7'h00, count_addr_i[16]};
                    3'd1: next_r.d = count_addr_i[15:8];
                    3'd2: next_r.d = count_addr_i[7:0];
                    3'd3: next_r.d = {7'h00, start_addr_i[16]};
                    3'd4: next_r.d = start_addr_i[15:8];
                    3'd5: next_r.d = start_addr_i[7:0];
                    default: next_r.d = str_data_i;
                endcase
                if (r.pos != 3'd6) begin
                    next_r.v = 1'b1;
                    next_r.ph = 1'b0;
                    next_r.pos = r.pos + 3'd1;
                    if (r.pos == 3'd5 && !r.send_str) begin
                        next_r.st = SPW_H_WAIT;
                    end
                end else if (!r.ph) begin
                    // device needs a spare cycle per string byte for its flash compare
                    next_r.v = 1'b1;
                    next_r.ph = 1'b1;
                    next_r.idx = r.idx + 8'h01;
                    if (r.idx == str_len_i - 8'h01) begin
                        next_r.st = SPW_H_WAIT;
                    end
                end else begin
                    next_r.ph = 1'b0;
                end
            end
            SPW_H_WAIT: begin
                if (link.tx_valid) begin
                    next_r.status = link.tx_data;
                    next_r.done = 1'b1;
                    next_r.st = SPW_H_IDLE;
                end
            end
            default: next_r.st = SPW_H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.rx_valid = r.v;
    assign link.rx_data = r.d;
    assign str_rd_o = (r.st == SPW_H_SEND) && (r.pos == 3'd6) && !r.ph;
    assign str_idx_o = r.idx;
    assign done_o = r.done;
    assign status_o = r.status;
endmodule
`default_nettype wire

// ===== testbench/spw_assertions.sv
// link checker for the password gate
`include "spw_regs.svh"
`default_nettype none
module spw_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic seen;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // received byte count and first status seen
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            seen <= 1'b0;
        end else begin
            if (rx_valid && cnt != 8'hFF) begin
                cnt <= cnt + 8'h01;
            end
            if (tx_valid) begin
                seen <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_pulse; tx_valid |=> !tx_valid; endproperty
    property p_code; tx_valid |-> tx_data inside {`SPW_STATUS_OK, `SPW_STATUS_BLANK}; endproperty
    property p_once; tx_valid |-> !seen; endproperty
    property p_msb; rx_valid && (cnt == 8'h00 || cnt == 8'h03) |-> rx_data[7:1] == 7'h00; endproperty
    property p_blank; tx_valid && tx_data == `SPW_STATUS_BLANK |-> cnt >= 8'h06; endproperty
    property p_str; tx_valid && tx_data == `SPW_STATUS_OK |-> cnt >= 8'h0E; endproperty
    property p_quiet; $fell(rst_i) |-> !tx_valid [*8]; endproperty
    property p_end; $rose(tx_valid) |=> !rx_valid [*4]; endproperty
    a_pulse: assert property (p_pulse) else $error("status strobe too long");
    a_code: assert property (p_code) else $error("bad status code");
    a_once: assert property (p_once) else $error("second status byte");
    a_msb: assert property (p_msb) else $error("address top byte too wide");
    a_blank: assert property (p_blank) else $error("blank status before both addresses");
    a_str: assert property (p_str) else $error("grant before eight string bytes");
    a_quiet: assert property (p_quiet) else $error("status right after reset");
    a_end: assert property (p_end) else $error("bytes after status");
    c_blank: cover property (tx_valid && tx_data == `SPW_STATUS_BLANK);
    c_ok: cover property (tx_valid && tx_data == `SPW_STATUS_OK);
    c_addr: cover property (rx_valid && cnt == 8'h05);
endmodule
`default_nettype wire

// ===== testbench/tb_serial_prog_password_check.sv
// self-checking bench: device and controller joined over the link
`include "spw_regs.svh"
`default_nettype none
module tb_serial_prog_password_check;
    timeunit 1ns;
    timeprecision 1ps;
    import spw_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic smode = 1'b0, dbg = 1'b0, start = 1'b0, go = 1'b0, sstr = 1'b0;
    spw_byte_t cmd = 8'h00, slen = 8'h00, str_idx, status, fl_data, str_data, nr;
    spw_addr_t ca = 17'h0_0000, sa = 17'h0_0000, fl_addr;
    logic fl_rd, str_rd, done, granted, pw_err, blank, busy, e_prev;
    logic [7:0] mem [0:131071];
    logic [7:0] pw [0:255];
    logic [8:0] q [$];
    int n_fail = 0, checks = 0, cs = 0, n_done = 0, n_rd = 0;
    spw_link_if link ();
    assign fl_data = mem[fl_addr];
    assign str_data = pw[str_idx];
    spw_device i_spw_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .serial_mode_i(smode),
        .on_chip_debug_i(dbg), .start_i(start), .cmd_i(cmd), .fl_rd_o(fl_rd), .fl_addr_o(fl_addr),
        .fl_data_i(fl_data), .granted_o(granted), .pw_error_o(pw_err), .blank_o(blank), .busy_o(busy));
    spw_host i_spw_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .go_i(go), .send_string_i(sstr),
        .count_addr_i(ca), .start_addr_i(sa), .str_len_i(slen), .str_rd_o(str_rd), .str_idx_o(str_idx),
        .str_data_i(str_data), .done_o(done), .status_o(status));
    spw_assertions i_spw_assertions (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rx_valid(link.rx_valid),
        .rx_data(link.rx_data), .tx_valid(link.tx_valid), .tx_data(link.tx_data));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] got);
        checks++;
        if (q.size() == 0 || q[0] !== got) begin
            n_fail++;
            $display("ERROR %0t unexpected link outcome %h", $time, got);
        end
        if (q.size() != 0) void'(q.pop_front());
    endtask
    task automatic chk_lvl(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t level mismatch, got %b", $time, got);
        end
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        tk(5);
        rst_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // status bytes and error onsets taken off the note queue
    always @(negedge ref_clk_i) begin
        e_prev <= pw_err;
        if (done === 1'b1) n_done++;
        if (fl_rd === 1'b1) n_rd++;
        if (link.tx_valid === 1'b1) chk({1'b0, link.tx_data});
        if (pw_err === 1'b1 && e_prev !== 1'b1) chk(9'h100);
    end
    task automatic run_case(input spw_byte_t c, input logic bl, input spw_addr_t a, input spw_addr_t b,
            input spw_byte_t n, input int m, input logic ok);
        spw_byte_t base;
        int d0;
        int r0;
        base = 8'(8'h10 + $urandom % 64);
        do_reset();
        d0 = n_done;
        r0 = n_rd;
        for (int i = 0; i < int'(n); i++) mem[b + 17'(i)] = (m == 2 && i inside {[2:4]}) ? 8'h55 : 8'(base + 3 * i);
        for (int i = 0; i < 32; i++) mem[17'h1_FFE0 + 17'(i)] = (!bl && i == int'(base[4:0])) ? 8'h5A : 8'hFF;
        mem[a] = n;
        for (int i = 0; i < 256; i++) pw[i] = mem[b + 17'(i)];
        if (m == 1) pw[5] = ~pw[5];
        if (m == 3) pw[0] = 8'h11;
        if (m == 3) pw[1] = `SPW_REC_MARK;
        q.push_back(ok ? {1'b0, bl ? `SPW_STATUS_BLANK : `SPW_STATUS_OK} : 9'h100);
        cs++;
        smode <= cs[0];
        dbg <= !cs[0];
        tk(3);
        cmd <= c;
        start <= 1'b1;
        tk(1);
        start <= 1'b0;
        tk(70);
        chk_lvl(busy, 1'b1);
        ca <= a;
        sa <= b;
        slen <= (m == 3) ? 8'h02 : n;
        sstr <= !bl || m == 3;
        go <= 1'b1;
        tk(1);
        go <= 1'b0;
        for (int k = 0; k < 4000 && granted !== 1'b1 && pw_err !== 1'b1; k++) tk(1);
        tk(8);
        chk_lvl(granted, ok);
        chk_lvl(pw_err, !ok);
        chk_lvl(blank, bl);
        chk_lvl(q.size() == 0, 1'b1);
        if (ok) chk_lvl(status === (bl ? `SPW_STATUS_BLANK : `SPW_STATUS_OK), 1'b1);
        chk_lvl(busy, 1'b0);
        chk_lvl(n_done - d0 == int'(ok), 1'b1);
        if (ok) chk_lvl(n_rd - r0 == 33 + (bl ? 0 : int'(n)), 1'b1);
        if (!ok) begin
            go <= 1'b1;
            start <= 1'b1;
            tk(1);
            go <= 1'b0;
            start <= 1'b0;
            tk(200);
            chk_lvl(granted, 1'b0);
            chk_lvl(pw_err, 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(27020));
        nr = 8'(8 + $urandom % 248);
        run_case(`SPW_CMD_ERASE, 1'b0, 17'h0_1000, 17'h0_1000, nr, 0, 1'b1);
        run_case(`SPW_CMD_WRITE, 1'b0, 17'h1_FEFF, 17'h1_FEF8, 8'h08, 0, 1'b1);
        run_case(`SPW_CMD_LOADER, 1'b0, 17'h0_1000, 17'h1_FE01, 8'hFF, 0, 1'b1);
        run_case(`SPW_CMD_READ, 1'b0, 17'h0_1000, 17'h1_FEF9, 8'h08, 0, 1'b0);
        run_case(`SPW_CMD_SECURE, 1'b0, 17'h0_0FFF, 17'h0_1000, 8'h08, 0, 1'b0);
        run_case(`SPW_CMD_WRITE, 1'b0, 17'h1_FF00, 17'h0_1000, 8'h08, 0, 1'b0);
        run_case(`SPW_CMD_ERASE, 1'b0, 17'h0_1000, 17'h0_1100, 8'h07, 0, 1'b0);
        run_case(`SPW_CMD_READ, 1'b0, 17'h0_1000, 17'h0_1100, nr, 1, 1'b0);
        run_case(`SPW_CMD_LOADER, 1'b0, 17'h0_1000, 17'h0_1100, 8'h0A, 2, 1'b0);
        run_case(`SPW_CMD_ERASE, 1'b1, 17'h1_FEFF, 17'h1_FEFF, 8'h00, 0, 1'b1);
        run_case(`SPW_CMD_READ, 1'b1, 17'h0_1000, 17'h1_FF00, 8'h08, 0, 1'b0);
        run_case(`SPW_CMD_WRITE, 1'b1, 17'h0_1000, 17'h0_1000, 8'h08, 3, 1'b1);
        do_reset();
        smode <= 1'b1;
        dbg <= 1'b0;
        tk(3);
        cmd <= 8'h90;
        start <= 1'b1;
        tk(1);
        start <= 1'b0;
        tk(70);
        chk_lvl(granted, 1'b1);
        chk_lvl(busy, 1'b0);
        chk_lvl(link.tx_valid, 1'b0);
        do_reset();
        smode <= 1'b0;
        dbg <= 1'b0;
        tk(3);
        start <= 1'b1;
        tk(1);
        start <= 1'b0;
        tk(3);
        chk_lvl(busy, 1'b0);
        chk_lvl(granted, 1'b0);
        stop_test();
    end
    initial begin
        tk(60000);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire
